// ---- hdl/mcs_sequencer.sv ----
// Contract
// R1 - stop request halts at selected stop state
// R2 - resume request leaves halt, resumes running
// R3 - peripheral pulls stretch request low for waits
// R4 - stretch request sampled at sample point select
// R5 - peripheral pulls ready low to resume
// R6 - ack low after sample, until two after ready
// R7 - single step runs exactly one microcycle
// R8 - step contact pair debounced into one event
// R9 - open contact low switches halt to run
// R10 - stepped microcycle ends at selected stop state
// R11 - all flops on oscillator clock, clock copied out
// R12 - length latch enable is phase clock 1
// R13 - four phase clocks with distinct duty patterns
// R14 - phase clock 3 about half high
// R15 - phase clock 2 low final two cycles
// R16 - three-bit code selects length three to ten
// R17 - length code latched at microcycle end
// R18 - resume, stop, step inputs in set-reset storage
// R19 - counter and phases hold during stretch
// R20 - stop request acted on only at stop state
`timescale 1ns/10ps
`include "mcs_defines.svh"

module mcs_sequencer (
    // clock and reset
    input  wire logic              hclk,
    input  wire logic              hresetn,
    // ahb-lite slave
    input  wire logic              hsel,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic                   hreadyout,
    output logic                   hresp,
    output logic      [31:0]       hrdata,
    // front panel, peripheral and microcode pins
    input  wire mcs_pkg::mcs_pins_s pins,
    // clock outputs and stretch acknowledge
    output logic                   osc_clock_out,
    output mcs_pkg::mcs_phase_s    phases,
    output logic                   stretch_ack_n
);
    import mcs_pkg::*;

    // ---------------------------------------------------------------
    // functions
    // ---------------------------------------------------------------
    function automatic mcs_cnt_t last_idx(input logic [2:0] code);
        last_idx = {1'b0, code} + `MCS_LEN_MIN - 4'h1; // R16
    endfunction

    function automatic mcs_cnt_t stop_idx(input logic [2:0] code,
                                          input logic       first);
        stop_idx = first ? `MCS_CNT_RST : last_idx(code);
    endfunction

    function automatic mcs_phase_s phase_of(input mcs_cnt_t   c,
                                            input logic [2:0] code);
        mcs_cnt_t   l;
        mcs_phase_s p;
        l             = last_idx(code);
        p.phase_clk_1 = (c != l);                        // R13
        p.phase_clk_2 = (c < l - 4'h1);                  // R15
        p.phase_clk_3 = ({c, 1'b0} < {1'b0, l} + 5'h1);  // R14
        p.phase_clk_4 = (c != `MCS_CNT_RST);
        phase_of      = p;
    endfunction

    // ---------------------------------------------------------------
    // pin synchronisers
    // ---------------------------------------------------------------
    mcs_pins_s pins_s;

    mcs_sync #(
        .WIDTH   ($bits(mcs_pins_s)),
        .RST_VAL (`MCS_PINS_RST)
    ) u_sync (
        .hclk    (hclk),
        .hresetn (hresetn),
        .pin     (pins),
        .level   (pins_s)
    );

    // ---------------------------------------------------------------
    // ahb-lite slave
    // ---------------------------------------------------------------
    logic       wr_pend_q;
    logic [7:0] wr_addr_q;
    logic       soft_stop_q;
    logic       soft_step_q;
    logic       ahb_take;

    assign ahb_take = hsel && htrans[1] && hready;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
        end else begin
            wr_pend_q <= ahb_take && hwrite;
            if (ahb_take) begin
                wr_addr_q <= haddr[7:0];
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            soft_stop_q <= `MCS_CTRL_RST;
            soft_step_q <= 1'b0;
        end else begin
            soft_step_q <= 1'b0;
            if (wr_pend_q && wr_addr_q == `MCS_CTRL_ADDR) begin
                soft_stop_q <= hwdata[`MCS_CTRL_STOP_BIT];
                soft_step_q <= hwdata[`MCS_CTRL_STEP_BIT];
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // set-reset storage for panel inputs
    // ---------------------------------------------------------------
    logic halt_sr_q;
    logic step_sr_q;
    logic step_sr_d1_q;
    logic step_go;
    logic stop_req;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            halt_sr_q <= 1'b0;
        end else if (!pins_s.stop_n && pins_s.resume_n) begin
            halt_sr_q <= 1'b1; // R18
        end else if (!pins_s.resume_n && pins_s.stop_n) begin
            halt_sr_q <= 1'b0; // R18
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            step_sr_q    <= 1'b0;
            step_sr_d1_q <= 1'b0;
        end else begin
            step_sr_d1_q <= step_sr_q;
            if (!pins_s.step_contact_open_n
                && pins_s.step_contact_closed_n) begin
                step_sr_q <= 1'b1; // R8
            end else if (!pins_s.step_contact_closed_n
                         && pins_s.step_contact_open_n) begin
                step_sr_q <= 1'b0; // R8
            end
        end
    end

    assign step_go  = (step_sr_q && !step_sr_d1_q) || soft_step_q; // R9
    assign stop_req = halt_sr_q || soft_stop_q;

    // ---------------------------------------------------------------
    // wait stretch
    // ---------------------------------------------------------------
    mcs_wait_e wst_q;
    mcs_wait_e wst_d;
    logic      sel_d1_q;
    logic      sel_fall;

    assign sel_fall = !pins_s.sample_point_select_n && sel_d1_q;

    always_comb begin
        wst_d = wst_q;
        unique case (wst_q)
            WST_IDLE: begin
                if (sel_fall && !pins_s.stretch_request_n) begin
                    wst_d = WST_WAIT; // R4
                end
            end
            WST_WAIT: begin
                if (!pins_s.ready_n) begin
                    wst_d = WST_REL; // R6
                end
            end
            WST_REL: begin
                wst_d = WST_IDLE;
            end
            default: begin
                wst_d = WST_IDLE;
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wst_q         <= WST_IDLE;
            sel_d1_q      <= 1'b1;
            stretch_ack_n <= 1'b1;
        end else begin
            wst_q         <= wst_d;
            sel_d1_q      <= pins_s.sample_point_select_n;
            stretch_ack_n <= (wst_d == WST_IDLE); // R6
        end
    end

    // ---------------------------------------------------------------
    // microcycle counter, length latch and halt
    // ---------------------------------------------------------------
    mcs_cnt_t   cnt_q;
    mcs_cnt_t   cnt_d;
    logic [2:0] len_q;
    logic [2:0] len_d;
    logic       halted_q;
    logic       advance;
    logic       at_end;

    assign advance = !halted_q && (wst_q == WST_IDLE); // R19
    assign at_end  = !phases.phase_clk_1;              // R12

    always_comb begin
        cnt_d = cnt_q;
        len_d = len_q;
        if (advance) begin
            if (at_end) begin
                cnt_d = `MCS_CNT_RST;
                len_d = pins_s.length_code; // R17
            end else begin
                cnt_d = cnt_q + 4'h1;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_q  <= `MCS_CNT_RST;
            len_q  <= `MCS_LEN_CODE_RST;
            phases <= mcs_phase_s'(`MCS_PHASE_RST);
        end else begin
            cnt_q  <= cnt_d;
            len_q  <= len_d;
            phases <= phase_of(cnt_d, len_d); // R13
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            halted_q <= 1'b0;
        end else if (halted_q) begin
            if (step_go || !stop_req) begin
                halted_q <= 1'b0; // R2 R7 R9
            end
        end else if (advance && stop_req
                     && cnt_d == stop_idx(len_d, pins_s.stop_first)) begin
            halted_q <= 1'b1; // R1 R10 R20
        end
    end

    // buffered copy of the oscillator clock
    assign osc_clock_out = hclk; // R11

    // ---------------------------------------------------------------
    // status readback
    // ---------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (ahb_take && !hwrite) begin
            hrdata <= 32'h0000_0000;
            if (haddr[7:0] == `MCS_CTRL_ADDR) begin
                hrdata[`MCS_CTRL_STOP_BIT] <= soft_stop_q;
            end else if (haddr[7:0] == `MCS_STAT_ADDR) begin
                hrdata[`MCS_STAT_CNT_LSB +: 4] <= cnt_q;
                hrdata[`MCS_STAT_LEN_LSB +: 3] <= len_q;
                hrdata[`MCS_STAT_HALT_BIT]     <= halted_q;
                hrdata[`MCS_STAT_WAIT_BIT]     <= (wst_q != WST_IDLE);
                hrdata[`MCS_STAT_PH_LSB +: 4]  <= phases;
            end
        end
    end

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence s_sampled;
        wst_q == WST_IDLE && sel_fall && !pins_s.stretch_request_n;
    endsequence

    sequence s_ready_seen;
        wst_q == WST_WAIT && !pins_s.ready_n;
    endsequence

    a_halt_stop_point: assert property ( // R1
        $rose(halted_q) |->
            cnt_q == stop_idx(len_q, $past(pins_s.stop_first)))
        else $error("halt entered away from stop state");

    a_resume_leaves: assert property ( // R2
        halted_q && !stop_req |=> !halted_q)
        else $error("resume did not leave halt");

    a_ack_on_sample: assert property ( // R6
        s_sampled |=> !stretch_ack_n)
        else $error("ack not low after sample point");

    a_ack_release: assert property ( // R6
        s_ready_seen |=> !stretch_ack_n ##1 stretch_ack_n)
        else $error("ack release not two cycles after ready");

    a_hold_in_wait: assert property ( // R19
        wst_q != WST_IDLE |=> $stable(cnt_q) && $stable(phases))
        else $error("counter moved during stretch");

    a_step_runs: assert property ( // R7
        halted_q && step_go |=> !halted_q ##1 cnt_q != $past(cnt_q, 2)
            || wst_q != WST_IDLE)
        else $error("step did not start a microcycle");

    a_len_latch: assert property ( // R17
        advance && at_end |=> len_q == $past(pins_s.length_code))
        else $error("length code not latched at end");

    a_c2_tail: assert property ( // R15
        phases.phase_clk_2 == (cnt_q < last_idx(len_q) - 4'h1))
        else $error("phase clock 2 wrong in tail");

    a_c1_wrap: assert property ( // R12
        advance && !phases.phase_clk_1 |=> cnt_q == `MCS_CNT_RST)
        else $error("counter did not wrap after phase 1 low");

    a_count_range: assert property ( // R16
        cnt_q <= last_idx(len_q))
        else $error("counter beyond selected length");

endmodule

// ---- hdl/mcs_defines.svh ----
`ifndef MCS_DEFINES_SVH
`define MCS_DEFINES_SVH

// ---------------------------------------------------------------
// register map
// ---------------------------------------------------------------
`define MCS_CTRL_ADDR      8'h00
`define MCS_STAT_ADDR      8'h04
`define MCS_CTRL_STOP_BIT  0
`define MCS_CTRL_STEP_BIT  1
`define MCS_STAT_CNT_LSB   0
`define MCS_STAT_LEN_LSB   4
`define MCS_STAT_HALT_BIT  7
`define MCS_STAT_WAIT_BIT  8
`define MCS_STAT_PH_LSB    9
`define MCS_CTRL_RST       1'b0

// ---------------------------------------------------------------
// microcycle timing
// ---------------------------------------------------------------
`define MCS_LEN_MIN        4'h3
`define MCS_LEN_CODE_RST   3'h0
`define MCS_CNT_RST        4'h0
`define MCS_PHASE_RST      4'he
`define MCS_PINS_RST       11'h7f0

`endif

// ---- hdl/mcs_pkg.sv ----
package mcs_pkg;

    // pins from the outside world, all active low except stop_first and length_code
    typedef struct packed {
        logic       resume_n;
        logic       stop_n;
        logic       step_contact_open_n;
        logic       step_contact_closed_n;
        logic       stretch_request_n;
        logic       sample_point_select_n;
        logic       ready_n;
        logic       stop_first;
        logic [2:0] length_code;
    } mcs_pins_s;

    typedef struct packed {
        logic phase_clk_1;
        logic phase_clk_2;
        logic phase_clk_3;
        logic phase_clk_4;
    } mcs_phase_s;

    typedef enum logic [2:0] {
        WST_IDLE = 3'b001,
        WST_WAIT = 3'b010,
        WST_REL  = 3'b100
    } mcs_wait_e;

    typedef logic [3:0] mcs_cnt_t;

endpackage

// ---- hdl/mcs_sync.sv ----
`timescale 1ns/10ps

module mcs_sync #(
    parameter int                WIDTH   = 1,
    parameter logic [WIDTH-1:0]  RST_VAL = '0
) (
    // clock and reset
    input  wire logic             hclk,
    input  wire logic             hresetn,
    // pins in, clean level out
    input  wire logic [WIDTH-1:0] pin,
    output logic      [WIDTH-1:0] level
);

    logic [WIDTH-1:0] s1_q;
    logic [WIDTH-1:0] s2_q;
    logic [WIDTH-1:0] s3_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s1_q <= RST_VAL;
            s2_q <= RST_VAL;
            s3_q <= RST_VAL;
        end else begin
            s1_q <= pin;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // a bit changes only once stages two and three agree
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            level <= RST_VAL;
        end else begin
            for (int i = 0; i < WIDTH; i++) begin
                if (s2_q[i] == s3_q[i]) begin
                    level[i] <= s3_q[i];
                end
            end
        end
    end

endmodule

// ---- bench/mcs_far_end.sv ----
`timescale 1ns/10ps
// ----------------------------------------
// front panel contacts and slow peripheral
// ----------------------------------------
module mcs_far_end (
    // clock and reset
    input  wire logic          hclk,
    input  wire logic          hresetn,
    // commands from the bench
    input  wire logic          stop_req,
    input  wire logic          resume_req,
    input  wire logic          step_go,
    input  wire logic          wait_go,
    input  wire logic          stop_first,
    input  wire logic [2:0]    length_code,
    // sequencer side
    input  wire logic          stretch_ack_n,
    output mcs_pkg::mcs_pins_s pins
);
    import mcs_pkg::*;
    logic [5:0] st_q;
    logic [3:0] rd_q;
    logic [1:0] sd_q;
    logic       wt_q;

    // press runs break, bouncing make, release
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_q <= 6'h00;
        end else if (st_q != 6'h00 || step_go) begin
            st_q <= st_q + 6'h01;
        end
    end

    // wait: request, late select, slow ready
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wt_q <= 1'b0;
            rd_q <= 4'h0;
            sd_q <= 2'h0;
        end else begin
            sd_q <= {sd_q[0], wt_q};
            if (!wt_q) begin
                wt_q <= wait_go;
                rd_q <= 4'h0;
            end else if (rd_q == 4'hf) begin
                wt_q <= ~stretch_ack_n;
            end else if (rd_q != 4'h0 || !stretch_ack_n) begin
                rd_q <= rd_q + 4'h1;
            end
        end
    end

    always_comb begin
        pins.resume_n = ~resume_req;
        pins.stop_n = ~stop_req;
        pins.step_contact_open_n = !(st_q > 6'h04 && st_q < 6'h28
            && st_q != 6'h06 && st_q != 6'h08);
        pins.step_contact_closed_n = !(st_q == 6'h00 || st_q > 6'h2a);
        pins.stretch_request_n = ~wt_q;
        pins.sample_point_select_n = ~sd_q[1];
        pins.ready_n = ~(wt_q && rd_q == 4'hf);
        pins.stop_first = stop_first;
        pins.length_code = length_code;
    end
endmodule

// ---- bench/tb_microcycle_clock_sequencer.sv ----
`timescale 1ns/10ps
module tb_microcycle_clock_sequencer;
    import mcs_pkg::*;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
    logic        osc_clock_out;
    logic        stretch_ack_n;
    mcs_phase_s  phases;
    mcs_pins_s   pins;
    logic        stopq = 1'b0;
    logic        resq = 1'b0;
    logic        stepq = 1'b0;
    logic        waitq = 1'b0;
    logic        sfirst = 1'b0;
    logic [2:0]  lcode = 3'h0;
    logic [31:0] rnd = 32'h66d5d089;
    logic [31:0] exp_q[$];
    logic [31:0] seen_q[$];
    event        got_ev;
    int          bad_count = 0;
    int          n_checks = 0;

    always #20 hclk = ~hclk;

    mcs_sequencer dut_u (
        .hclk         (hclk),
        .hresetn      (hresetn),
        .hsel         (hsel),
        .haddr        (haddr),
        .htrans       (htrans),
        .hwrite       (hwrite),
        .hsize        (hsize),
        .hwdata       (hwdata),
        .hready       (hreadyout),
        .hreadyout    (hreadyout),
        .hresp        (hresp),
        .hrdata       (hrdata),
        .pins         (pins),
        .osc_clock_out(osc_clock_out),
        .phases       (phases),
        .stretch_ack_n(stretch_ack_n)
    );

    mcs_far_end fe_u (
        .hclk         (hclk),
        .hresetn      (hresetn),
        .stop_req     (stopq),
        .resume_req   (resq),
        .step_go      (stepq),
        .wait_go      (waitq),
        .stop_first   (sfirst),
        .length_code  (lcode),
        .stretch_ack_n(stretch_ack_n),
        .pins         (pins)
    );

    // ----------------------------------------
    // compare and report
    // ----------------------------------------
    function automatic logic [31:0] lfsr_nx(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic check(input logic [31:0] s, input logic [31:0] e);
        n_checks++;
        if (s !== e) begin
            bad_count++;
            $display("wrong value at %0t: saw %h want %h", $time, s, e);
        end
    endtask

    task automatic drain;
        while (seen_q.size() > 0 && exp_q.size() > 0)
            check(seen_q.pop_front(), exp_q.pop_front());
    endtask

    always begin
        @(got_ev);
        drain();
    end

    task automatic rec(input logic [31:0] s, input logic [31:0] e);
        exp_q.push_back(e);
        seen_q.push_back(s);
        ->got_ev;
    endtask

    task automatic wrap_up;
        drain();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic done(input string s);
        $display("test %s finished", s);
    endtask

    // ----------------------------------------
    // bus and phase helpers
    // ----------------------------------------
    task automatic ahb(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd, output logic [31:0] rd);
        int n;
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h0, a};
        hwrite <= wr;
        n = 0;
        do begin @(posedge hclk); n++; end
        while (hreadyout !== 1'b1 && n < 50);
        if (hreadyout !== 1'b1) bad_count++;
        htrans <= 2'b00;
        hwdata <= wd;
        n = 0;
        do begin @(posedge hclk); n++; end
        while (hreadyout !== 1'b1 && n < 50);
        if (hreadyout !== 1'b1) bad_count++;
        rd = hrdata;
    endtask

    task automatic meas(output int n, output int a, output int b,
                        output int c);
        int k;
        k = 0;
        do begin @(negedge hclk); k++; end
        while (phases.phase_clk_1 !== 1'b0 && k < 40);
        n = 0;
        a = 0;
        b = 0;
        c = 0;
        do begin
            @(negedge hclk);
            n++;
            a += int'(phases.phase_clk_2 === 1'b0);
            b += int'(phases.phase_clk_3 === 1'b1);
            c += int'(phases.phase_clk_4 === 1'b0);
        end while (phases.phase_clk_1 !== 1'b0 && n < 40);
    endtask

    task automatic falls(input int cyc, input bit c4, output int f);
        logic p;
        logic v;
        f = 0;
        p = c4 ? phases.phase_clk_4 : phases.phase_clk_1;
        repeat (cyc) begin
            @(negedge hclk);
            v = c4 ? phases.phase_clk_4 : phases.phase_clk_1;
            f += int'(p === 1'b1 && v === 1'b0);
            p = v;
        end
    endtask

    task automatic hstep(input bit first);
        int f;
        falls(30, first, f);
        rec(32'(f), 32'h0);
        rec(32'(phases[first ? 0 : 3]), 32'h0);
        @(posedge hclk);
        stepq <= 1'b1;
        @(posedge hclk);
        stepq <= 1'b0;
        falls(80, first, f);
        rec(32'(f), 32'h1);
        rec(32'(phases[first ? 0 : 3]), 32'h0);
    endtask

    task automatic resume;
        int f;
        @(posedge hclk);
        stopq <= 1'b0;
        resq <= 1'b1;
        repeat (10) @(posedge hclk);
        resq <= 1'b0;
        falls(60, 1'b0, f);
        rec(32'(f > 2), 32'h1);
    endtask

    // ----------------------------------------
    // test sequence
    // ----------------------------------------
    initial begin
        int n, a, b, c, f, i;
        logic [31:0] rd;
        logic [2:0]  code;
        mcs_phase_s  ph;
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rec(32'({hreadyout, hresp, stretch_ack_n}), 32'h5);
        ahb(1'b0, 8'h08, 32'h0, rd);
        rec(rd, 32'h0);
        ahb(1'b0, 8'h00, 32'h0, rd);
        rec(rd, 32'h0);
        #10 rec(32'(osc_clock_out), 32'(hclk));
        done("reset");
        rnd = lfsr_nx(rnd);
        for (i = 0; i < 8; i++) begin
            code = 3'(i) ^ rnd[2:0];
            @(posedge hclk);
            lcode <= code;
            repeat (3) meas(n, a, b, c);
            rec(32'(n), 32'(code) + 32'd3);
            rec(32'(a), 32'd2);
            rec(32'(b), (32'(code) + 32'd4) / 32'd2);
            rec(32'(c), 32'd1);
            @(posedge hclk);
            ahb(1'b0, 8'h04, 32'h0, rd);
            rec(32'(rd[6:4]), 32'(code));
        end
        done("lengths");
        @(posedge hclk);
        stopq <= 1'b1;
        repeat (20) @(posedge hclk);
        ahb(1'b0, 8'h04, 32'h0, rd);
        rec(32'(rd[7]), 32'h1);
        hstep(1'b0);
        resume();
        @(posedge hclk);
        sfirst <= 1'b1;
        stopq <= 1'b1;
        repeat (20) @(posedge hclk);
        hstep(1'b1);
        resume();
        done("halt");
        rnd = lfsr_nx(rnd);
        @(posedge hclk);
        ahb(1'b1, 8'h00, (rnd & ~32'h2) | 32'h1, rd);
        repeat (20) @(posedge hclk);
        ahb(1'b0, 8'h00, 32'h0, rd);
        rec(32'(rd[1:0]), 32'h1);
        ahb(1'b0, 8'h04, 32'h0, rd);
        rec(32'(rd[7]), 32'h1);
        ahb(1'b1, 8'h00, 32'h3, rd);
        falls(40, 1'b1, f);
        rec(32'(f), 32'h1);
        @(posedge hclk);
        ahb(1'b1, 8'h00, 32'h0, rd);
        repeat (10) @(posedge hclk);
        ahb(1'b0, 8'h04, 32'h0, rd);
        rec(32'(rd[7]), 32'h0);
        done("soft");
        @(posedge hclk);
        waitq <= 1'b1;
        @(posedge hclk);
        waitq <= 1'b0;
        n = 0;
        do begin @(negedge hclk); n++; end
        while (pins.sample_point_select_n !== 1'b0 && n < 20);
        n = 0;
        do begin @(negedge hclk); n++; end
        while (stretch_ack_n !== 1'b0 && n < 20);
        rec(32'(n >= 2 && n <= 8), 32'h1);
        ph = phases;
        a = 0;
        b = 0;
        do begin
            @(negedge hclk);
            a++;
            b += int'(phases !== ph || stretch_ack_n !== 1'b0);
        end while (pins.ready_n !== 1'b0 && a < 40);
        rec(32'(b), 32'h0);
        n = 0;
        do begin @(negedge hclk); n++; end
        while (stretch_ack_n !== 1'b1 && n < 20);
        rec(32'(n >= 2 && n <= 8), 32'h1);
        done("stretch");
        wrap_up();
    end

    initial begin
        #(40 * 20000);
        bad_count++;
        wrap_up();
    end
endmodule
